// ### src/checksum_pkg.sv
// Constants and types for the modem check-word generator and checker.
// Assumes a single 20 MHz clock; bit ticks come from the modem bit timing.
package checksum_pkg;
   // Divider taps for x^15 + x^14 + x^13 + x^11 + x^4 + x^2 + 1
   localparam logic [14:0] POLY = 15'h6815;
   localparam int REM_W = 15;
   localparam int BYTE_W = 8;
   localparam int FIFO_DEPTH = 8;
   // Register select codes {A2, A1, A0}; A2 high marks a read
   localparam logic [2:0] ADDR_STATUS = 3'h7;
   localparam logic [2:0] ADDR_TX_DATA = 3'h2;
   localparam logic [2:0] ADDR_SYN_LOW = 3'h4;
   localparam logic [2:0] ADDR_SYN_HIGH = 3'h5;
   localparam int STATUS_PASS_BIT = 1;
   // Block counts
   localparam logic [2:0] TX_MSG_BYTES = 3'h6;
   localparam logic [2:0] TX_LAST_BYTE = 3'h7;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [5:0] RX_INVERT_IDX = 6'h3e;
   localparam logic [5:0] RX_PARITY_IDX = 6'h3f;
   // Reset values
   localparam logic [REM_W-1:0] REM_RESET = 15'h0000;
   localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;

   typedef struct packed {
      logic parityErr;
      logic [REM_W-1:0] rem;
   } syndrome_t;

   typedef struct packed {
      logic strobe;
      logic [2:0] addr;
      logic [BYTE_W-1:0] data;
   } pins_t;
endpackage

// ### src/block_checksum_syndrome.sv
// Check-word generator and checker with syndrome registers and a transmit byte FIFO.
// Assumes bus pins are asynchronous; bit ticks, receive bits, block start and
// check enable come from modem logic on the same clock.
// Function
// - Each transmit block feeds its 48 message bits from six host bytes into the divider.
// - The divider uses x^15+x^14+x^13+x^11+x^4+x^2+1 and leaves a 15-bit remainder.
// - The last remainder bit is inverted and even parity over message and remainder is added.
// - The check word goes out as the modified remainder followed by the parity bit.
// - On receive the first 63 bits are divided, with bit 63 inverted on entry.
// - After 63 bits the 15 divider bits are tested for all zero.
// - Even parity of the first 63 received bits is compared with received bit 64.
// - The pass flag is set only for a zero remainder and matching parity.
// - The high syndrome byte holds remainder bits 9 to 15 and the parity error in bit 7.
// - An error-free block shows all sixteen syndrome bits as zero.
// - The low syndrome byte holds remainder bits 1 to 8 left after the block.
// - With check insertion enabled two check bytes follow every six message bytes.
// - Both syndrome bytes become valid with the second check byte; host reads soon after.
// - Frame word detection is suppressed while a receive block is checked.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Small synchronous FIFO, depth a power of two
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = DEPTH[AW:0];
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_q;
   logic [AW-1:0] rdPtr_q;
   logic [AW:0] count_q;
   wire logic push = inValid && inReady;
   wire logic pop = outValid && outReady;

   // Honest flags from the occupancy count
   assign inReady = count_q != FULL;
   assign outValid = count_q != '0;
   assign outData = mem[rdPtr_q];

   // Storage has no reset; only the pointers matter
   always_ff @(posedge clk)
   begin
      if (push)
         mem[wrPtr_q] <= inData;
   end

   // Pointers and count
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end
      else
      begin
         if (push) wrPtr_q <= wrPtr_q + 1'b1;
         if (pop) rdPtr_q <= rdPtr_q + 1'b1;
         if (push && !pop) count_q <= count_q + 1'b1;
         else if (pop && !push) count_q <= count_q - 1'b1;
      end
   end
endmodule
////////////////////////////////////////////////////////////////////////////////
module block_checksum_syndrome (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic regStrobe,
   input wire logic [2:0] regAddr,
   input wire logic [7:0] dataIn,
   output logic [7:0] dataOut,
   output logic dataOe,
   input wire logic txCheckEnable,
   input wire logic txBitTick,
   output logic txBit,
   output logic txBufferReady,
   input wire logic rxBitTick,
   input wire logic rxBit,
   input wire logic rxBlockStart,
   output logic frameSuppress,
   output logic checksumTrue,
   output logic syndromeValid
);
   // One modulo-2 division step, message bit entering at the top
   function automatic logic [14:0] divStep(input logic [14:0] rem, input logic inBit);
      logic fb;
      fb = inBit ^ rem[14];
      return {rem[13:0], 1'b0} ^ (fb ? checksum_pkg::POLY : checksum_pkg::REM_RESET);
   endfunction
   /////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and strobe edge
   checksum_pkg::pins_t pinMeta_q;
   checksum_pkg::pins_t pinSync_q;
   logic strobePrev_q;
   logic [7:0] dataOut_q;
   logic dataOe_q;
   wire checksum_pkg::pins_t pinRaw = '{strobe: regStrobe, addr: regAddr, data: dataIn};
   wire logic strobeRise = pinSync_q.strobe && !strobePrev_q;
   wire logic hostRead = strobeRise && pinSync_q.addr[2];
   wire logic hostWrite = strobeRise && (pinSync_q.addr == checksum_pkg::ADDR_TX_DATA);

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pinMeta_q <= '0;
         pinSync_q <= '0;
         strobePrev_q <= 1'b0;
      end
      else
      begin
         pinMeta_q <= pinRaw;
         pinSync_q <= pinMeta_q;
         strobePrev_q <= pinSync_q.strobe;
      end
   end
   /////////////////////////////////////////////////////////////////////////////
   // Transmit FIFO: a write while full is dropped, so the host polls ready
   logic fifoValid;
   logic fifoReady;
   logic fifoPop;
   logic [7:0] fifoData;
   byte_fifo #(
      .WIDTH(checksum_pkg::BYTE_W),
      .DEPTH(checksum_pkg::FIFO_DEPTH)
   ) txFifo (
      .clk(clk),
      .reset_n(reset_n),
      .inValid(hostWrite),
      .inReady(fifoReady),
      .inData(pinSync_q.data),
      .outValid(fifoValid),
      .outReady(fifoPop),
      .outData(fifoData)
   );
   /////////////////////////////////////////////////////////////////////////////
   // Transmit serialiser and check-word generator
   logic [7:0] txShift_q;
   logic [2:0] txBitCnt_q;
   logic [2:0] txByteCnt_q;
   logic [14:0] txRem_q;
   logic txPar_q;
   logic txBit_q;
   logic txBufferReady_q;
   wire logic needByte = txBitCnt_q == '0;
   wire logic checkPhase = txCheckEnable && (txByteCnt_q >= checksum_pkg::TX_MSG_BYTES);
   wire logic [14:0] modRem = {txRem_q[14:1], ~txRem_q[0]};
   wire logic [15:0] checkWord = {modRem, txPar_q ^ (^modRem)};
   wire logic [7:0] checkByte = (txByteCnt_q == checksum_pkg::TX_MSG_BYTES) ?
      checkWord[15:8] : checkWord[7:0];
   wire logic [7:0] curByte = checkPhase ? checkByte : fifoData;
   wire logic outBit = needByte ? curByte[7] : txShift_q[7];
   wire logic txAdvance = txBitTick && (!needByte || checkPhase || fifoValid);
   wire logic msgBit = txCheckEnable && !checkPhase;
   wire logic byteDone = txAdvance && (txBitCnt_q == checksum_pkg::LAST_BIT);
   wire logic blockDone = byteDone && (txByteCnt_q == checksum_pkg::TX_LAST_BYTE);
   // FIFO is not drained while check bytes go out
   assign fifoPop = txBitTick && needByte && !checkPhase && fifoValid;

   // Bit shifter, MSB first
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         txShift_q <= checksum_pkg::BYTE_RESET;
         txBitCnt_q <= '0;
         txBit_q <= 1'b0;
         txBufferReady_q <= 1'b0;
      end
      else
      begin
         txBufferReady_q <= fifoReady;
         if (txAdvance)
         begin
            txShift_q <= needByte ? {curByte[6:0], 1'b0} : {txShift_q[6:0], 1'b0};
            txBitCnt_q <= txBitCnt_q + 3'h1;
            txBit_q <= outBit;
         end
      end
   end
   // Divider, parity and byte position within the block
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         txByteCnt_q <= '0;
         txRem_q <= checksum_pkg::REM_RESET;
         txPar_q <= 1'b0;
      end
      else if (!txCheckEnable || blockDone)
      begin
         txByteCnt_q <= '0;
         txRem_q <= checksum_pkg::REM_RESET;
         txPar_q <= 1'b0;
      end
      else if (txAdvance)
      begin
         if (msgBit)
         begin
            txRem_q <= divStep(txRem_q, outBit);
            txPar_q <= txPar_q ^ outBit;
         end
         if (byteDone)
            txByteCnt_q <= txByteCnt_q + 3'h1;
      end
   end
   /////////////////////////////////////////////////////////////////////////////
   // Receive checker; bit 64 ends the block and latches the syndrome
   logic rxBusy_q;
   logic [5:0] rxCnt_q;
   logic [14:0] rxRem_q;
   logic rxPar_q;
   checksum_pkg::syndrome_t syndrome_q;
   logic checksumTrue_q;
   logic syndromeValid_q;
   wire logic rxTake = rxBitTick && rxBusy_q && !rxBlockStart;
   wire logic rxEnd = rxTake && (rxCnt_q == checksum_pkg::RX_PARITY_IDX);
   wire logic divIn = (rxCnt_q == checksum_pkg::RX_INVERT_IDX) ? ~rxBit : rxBit;
   wire logic remZero = rxRem_q == checksum_pkg::REM_RESET;
   wire logic parErr = rxPar_q ^ rxBit;
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rxBusy_q <= 1'b0;
         rxCnt_q <= '0;
         rxRem_q <= checksum_pkg::REM_RESET;
         rxPar_q <= 1'b0;
      end
      else if (rxBlockStart)
      begin
         rxBusy_q <= 1'b1;
         rxCnt_q <= '0;
         rxRem_q <= checksum_pkg::REM_RESET;
         rxPar_q <= 1'b0;
      end
      else if (rxEnd)
         rxBusy_q <= 1'b0;
      else if (rxTake)
      begin
         rxCnt_q <= rxCnt_q + 6'h01;
         rxRem_q <= divStep(rxRem_q, divIn);
         rxPar_q <= rxPar_q ^ rxBit;
      end
   end

   // Syndrome held until the next block ends, pass flag until the next start; a start in the bit 64 tick cycle wins and that block's result is never latched
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         syndrome_q <= '0;
         checksumTrue_q <= 1'b0;
         syndromeValid_q <= 1'b0;
      end
      else
      begin
         syndromeValid_q <= rxEnd;
         if (rxEnd)
         begin
            syndrome_q <= '{parityErr: parErr, rem: rxRem_q};
            checksumTrue_q <= remZero && !parErr;
         end
         else if (rxBlockStart)
            checksumTrue_q <= 1'b0;
      end
   end
   /////////////////////////////////////////////////////////////////////////////
   // Register reads; A2 low is a write, so the bus is never driven then
   wire logic [7:0] statusByte = 8'(checksumTrue_q) << checksum_pkg::STATUS_PASS_BIT;
   wire logic [7:0] readData =
      (pinSync_q.addr == checksum_pkg::ADDR_SYN_LOW) ? syndrome_q[7:0] :
      (pinSync_q.addr == checksum_pkg::ADDR_SYN_HIGH) ? syndrome_q[15:8] :
      (pinSync_q.addr == checksum_pkg::ADDR_STATUS) ? statusByte : 8'h00;
   // Read byte captured once per strobe, so it cannot change mid-access
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         dataOut_q <= checksum_pkg::BYTE_RESET;
         dataOe_q <= 1'b0;
      end
      else
      begin
         dataOe_q <= pinSync_q.strobe && pinSync_q.addr[2];
         if (hostRead)
            dataOut_q <= readData;
      end
   end
   // Ports straight from their flops
   assign dataOut = dataOut_q;
   assign dataOe = dataOe_q;
   assign txBit = txBit_q;
   assign txBufferReady = txBufferReady_q;
   assign frameSuppress = rxBusy_q;
   assign checksumTrue = checksumTrue_q;
   assign syndromeValid = syndromeValid_q;
   /////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_pass_flag: assert property (rxEnd |=> checksumTrue_q ==
      ($past(remZero) && ($past(rxPar_q) == $past(rxBit))))
      else $error("pass flag does not match remainder and parity");
   a_parity_error: assert property (rxEnd |=> syndrome_q.parityErr == $past(parErr))
      else $error("parity error bit wrong");
   a_syndrome_low: assert property (rxEnd |=> syndrome_q[7:0] == $past(rxRem_q[7:0]))
      else $error("low syndrome byte wrong");
   a_syndrome_hold: assert property (!rxEnd |=> $stable(syndrome_q))
      else $error("syndrome changed outside block end");
   a_suppress_frame: assert property (rxBlockStart |=> frameSuppress [*2])
      else $error("frame detection not suppressed");
   a_start_clear: assert property (rxBlockStart |=> (rxRem_q == '0) && !rxPar_q)
      else $error("checker not cleared at block start");
   a_fifo_hold: assert property (checkPhase && !hostWrite |=> $stable(fifoValid))
      else $error("fifo drained during check bytes");
   a_tx_parity: assert property (blockDone && txCheckEnable |=> txBit_q == $past(checkWord[0]))
      else $error("parity bit not sent last");
   a_valid_pulse: assert property (rxEnd |=> syndromeValid_q ##1 !syndromeValid_q)
      else $error("syndrome valid pulse wrong");
   c_rx_pass: cover property (rxEnd ##1 checksumTrue_q);
   c_rx_fail: cover property (rxEnd ##1 !checksumTrue_q);
   c_tx_block: cover property (blockDone && txCheckEnable);
   c_fifo_full: cover property (!fifoReady);
endmodule
`default_nettype wire

// ### verification/host_bus_model.sv
// Host processor model: drives strobe, register select and data pins.
// Assumes the device samples these pins through its own synchronisers.
`timescale 1ns/1ps
`default_nettype none

module host_bus_model (
   input wire logic clk,
   output logic regStrobe,
   output logic [2:0] regAddr,
   output logic [7:0] dataIn,
   input wire logic [7:0] dataOut,
   input wire logic dataOe
);
   ////////////////////////////////////////////////////////////////////////////////
   // Idle pins from time zero
   initial
   begin
      regStrobe = 1'b0;
      regAddr = 3'h0;
      dataIn = 8'h5a;
   end

   // One access per strobe; held past the synchroniser delay, then a quiet gap
   task automatic busAccess(input logic [2:0] addr, input logic [7:0] wData,
      output logic [7:0] rData, output logic oeSeen);
      @(posedge clk);
      #2;
      regAddr = addr;
      dataIn = wData;
      regStrobe = 1'b1;
      repeat (6) @(posedge clk);
      #2;
      rData = dataOut;
      oeSeen = dataOe;
      regStrobe = 1'b0;
      // Released data shows the inverse so a stale byte cannot pass
      dataIn = ~wData;
      repeat (4) @(posedge clk);
   endtask
endmodule

`default_nettype wire

// ### verification/block_checksum_syndrome_tb_top.sv
// Self-checking bench for the check-word generator and checker.
// Assumes the host model drives the bus pins; bit ticks come from here.
`timescale 1ns/1ps
`default_nettype none

module block_checksum_syndrome_tb_top;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic regStrobe, dataOe, txBit, txBufferReady, frameSuppress, checksumTrue, syndromeValid;
   logic txCheckEnable = 1'b0;
   logic txBitTick = 1'b0;
   logic rxBitTick = 1'b0;
   logic rxBit = 1'b0;
   logic rxBlockStart = 1'b0;
   logic [2:0] regAddr;
   logic [7:0] dataIn, dataOut, expLow, expHigh, got;
   logic [63:0] blk1, blk2;
   int badCount = 0;
   int nTests = 0;

   always #25 clk = ~clk;

   host_bus_model host_u (.clk(clk), .regStrobe(regStrobe), .regAddr(regAddr),
      .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe));

   block_checksum_syndrome dut_u (.clk(clk), .reset_n(reset_n), .regStrobe(regStrobe),
      .regAddr(regAddr), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
      .txCheckEnable(txCheckEnable), .txBitTick(txBitTick), .txBit(txBit),
      .txBufferReady(txBufferReady), .rxBitTick(rxBitTick), .rxBit(rxBit),
      .rxBlockStart(rxBlockStart), .frameSuppress(frameSuppress),
      .checksumTrue(checksumTrue), .syndromeValid(syndromeValid));

   ////////////////////////////////////////////////////////////////////////////////
   // Compare helpers and verdict
   task automatic checkByte(input logic [7:0] g, input logic [7:0] e, input string what);
      nTests++;
      if (g !== e)
      begin
         badCount++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, g, e);
      end
   endtask

   task automatic checkBit(input logic g, input logic e, input string what);
      checkByte({7'h00, g}, {7'h00, e}, what);
   endtask

   task automatic giveVerdict();
      $display("comparisons %0d, mismatches %0d", nTests, badCount);
      if (badCount == 0 && nTests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Reference divider, independent of the design; feeds bits from the top
   function automatic logic [14:0] divide(input logic [62:0] bits, input int n);
      logic [14:0] r;
      logic fb;
      r = 15'h0000;
      for (int i = 0; i < n; i++)
      begin
         fb = bits[62-i] ^ r[14];
         r = {r[13:0], 1'b0} ^ (fb ? checksum_pkg::POLY : 15'h0000);
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Bus and bit-level drivers
   task automatic regRead(input logic [2:0] addr, output logic [7:0] d);
      logic oe;
      host_u.busAccess(addr, 8'h00, d, oe);
      checkBit(oe, 1'b1, "read drive");
   endtask

   task automatic hostWrite(input logic [7:0] d);
      logic [7:0] r;
      logic oe;
      host_u.busAccess(checksum_pkg::ADDR_TX_DATA, d, r, oe);
      checkBit(oe, 1'b0, "write drive");
   endtask

   // Output sampled two edges after the tick, once it has surely landed
   task automatic txTick(output logic b);
      @(posedge clk);
      #2 txBitTick = 1'b1;
      @(posedge clk);
      #2 txBitTick = 1'b0;
      repeat (2) @(posedge clk);
      #2 b = txBit;
   endtask

   // Start pulse then count bits, first bit at the top; data line scrambled between ticks
   task automatic rxBits(input logic [63:0] blk, input int count);
      @(posedge clk);
      #2 rxBlockStart = 1'b1;
      @(posedge clk);
      #2 rxBlockStart = 1'b0;
      for (int i = 63; i > 63 - count; i--)
      begin
         rxBit = blk[i];
         rxBitTick = 1'b1;
         @(posedge clk);
         #2 rxBitTick = 1'b0;
         rxBit = ~blk[i];
         if (i == 50) checkBit(frameSuppress, 1'b1, "suppress");
         if (i > 64 - count)
         begin
            @(posedge clk);
            #2;
         end
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   // Nine writes into eight places: the last is dropped, empty ticks hold the line
   task automatic fillAndDrain();
      logic b;
      logic [7:0] w;
      for (int i = 0; i < 9; i++) hostWrite(8'h30 + 8'(i));
      checkBit(txBufferReady, 1'b0, "buffer full");
      for (int k = 0; k < 8; k++)
      begin
         for (int j = 7; j >= 0; j--)
         begin
            txTick(b);
            w[j] = b;
         end
         checkByte(w, 8'h30 + 8'(k), "plain byte");
      end
      // A byte written to another register must never reach the line
      host_u.busAccess(3'h0, 8'h00, w, b);
      checkBit(b, 1'b0, "other write drive");
      txTick(b);
      checkBit(b, 1'b1, "empty hold");
      checkBit(txBufferReady, 1'b1, "buffer free");
   endtask

   // Six bytes out, then the check word; back to back shows the divider restarts
   task automatic txBlock(input logic [47:0] msg, output logic [63:0] blk);
      logic [14:0] r;
      logic [63:0] w;
      logic b;
      r = divide({msg, 15'h0000}, 48);
      blk = {msg, r[14:1], ~r[0], 1'b0};
      blk[0] = ^blk[63:1];
      txCheckEnable = 1'b1;
      for (int i = 5; i >= 0; i--) hostWrite(msg[i*8 +: 8]);
      for (int i = 63; i >= 0; i--)
      begin
         txTick(b);
         w[i] = b;
      end
      for (int k = 7; k >= 0; k--)
         checkByte(w[k*8 +: 8], blk[k*8 +: 8], "sent");
   endtask

   task automatic rxBlock(input logic [63:0] blk);
      logic [14:0] r;
      logic perr;
      int n;
      r = divide({blk[63:2], ~blk[1]}, 63);
      perr = (^blk[63:1]) ^ blk[0];
      expLow = r[7:0];
      expHigh = {perr, r[14:8]};
      rxBits(blk, 64);
      for (n = 0; n < 8 && syndromeValid !== 1'b1; n++)
      begin
         @(posedge clk);
         #2;
      end
      if (n == 8)
      begin
         badCount++;
         $display("unexpected at %0t: no syndrome pulse", $time);
         giveVerdict();
      end
      regRead(checksum_pkg::ADDR_SYN_LOW, got);
      checkByte(got, expLow, "syndrome low");
      regRead(checksum_pkg::ADDR_SYN_HIGH, got);
      checkByte(got, expHigh, "syndrome high");
      regRead(checksum_pkg::ADDR_STATUS, got);
      checkByte(got, {6'h00, ~perr & (r == 15'h0000), 1'b0}, "status");
      checkBit(checksumTrue, ~perr & (r == 15'h0000), "pass flag");
      checkBit(frameSuppress, 1'b0, "suppress end");
   endtask

   // Mid-block reads still show the previous block's syndrome
   task automatic holdSyndrome();
      rxBits(64'h0f0f_0f0f_0f0f_0f0f, 20);
      regRead(checksum_pkg::ADDR_SYN_LOW, got);
      checkByte(got, expLow, "held low");
      regRead(checksum_pkg::ADDR_SYN_HIGH, got);
      checkByte(got, expHigh, "held high");
      regRead(3'h6, got);
      checkByte(got, 8'h00, "unmapped");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (4) @(posedge clk);
      #2 reset_n = 1'b1;
      repeat (3) @(posedge clk);
      fillAndDrain();
      txBlock(48'h0123_4567_89ab, blk1);
      txBlock(48'hffee_ddcc_bbaa, blk2);
      rxBlock(blk1);
      rxBlock(blk1 ^ 64'h0000_0100_0000_0000);
      rxBlock(blk2 ^ 64'h0000_0000_0000_0001);
      rxBlock(blk2 ^ 64'h0000_0000_0000_0002);
      holdSyndrome();
      giveVerdict();
   end
endmodule

`default_nettype wire
